// ---- hdl/dual_timer_pin_select.sv ----
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "timer_pin_consts.svh"


module dual_timer_pin_select
   import timer_pin_pkg::*;
#(
   parameter int W = 16
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [7:0] timer_pin_in,
   output logic [7:0] timer_pin_out,
   output logic [7:0] timer_pin_oe_n,
   input wire logic fast_onchip_osc_clock_tick,
   output logic op_clock_fast
);

   logic [7:0] timer_output_disable_reg;
   logic [3:0] function_control_reg;
   logic [7:0] pwm_mode_select_reg;
   logic [7:0] ch0_io_control_ab;
   logic [7:0] ch0_io_control_cd;
   logic [7:0] ch1_io_control_ab;
   logic [7:0] ch1_io_control_cd;
   logic [4:0] ch0_control_reg;
   logic [4:0] ch1_control_reg;
   logic [7:0] port2_direction_reg;
   logic [7:0] port2_data_reg;
   logic [W-1:0] dead_time_reg;

   logic [1:0] combination_mode_field;
   logic external_clock_select;
   logic fixed_period_pwm_select_n;
   logic [2:0] count_source_code [2];
   logic [7:0] word_addr;
   logic accept;
   logic wr_go;
   logic [31:0] rd_mux;
   logic cmp_hit;
   logic [31:0] cmp_merged;
   logic [4:0] prescale;
   logic [1:0] src_tick;
   logic ext_tick;
   logic combined;
   logic fixed_mode;

   logic [1:0][W-1:0] cnt;
   logic [1:0] cnt_up;
   logic [1:0][3:0][W-1:0] cmp;
   logic [1:0][3:0] match;
   logic [1:0][3:0] cap_en;
   logic [1:0][3:0] cmp_we;
   logic [7:0] pin_prev;
   logic [7:0] next_out;
   logic [7:0] next_drive;
   logic [7:0] timer_owned;
   pin_func_t func [8];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic pick_tick(input logic [2:0] code, input logic [4:0] pre,
                                      input logic ext, input logic fast);
      logic t;
      case (code)
         `SRC_DIV1: t = 1'b1;
         `SRC_DIV2: t = pre[0];
         `SRC_DIV4: t = &pre[1:0];
         `SRC_DIV8: t = &pre[2:0];
         `SRC_DIV32: t = &pre[4:0];
         `SRC_EXT: t = ext;
         `SRC_FAST_OSC: t = fast;
         default: t = 1'b0;
      endcase
      return t;
   endfunction : pick_tick

   assign combination_mode_field = function_control_reg[`FC_CMD_MSB:`FC_CMD_LSB];
   assign external_clock_select = function_control_reg[`FC_EXT_CLK_BIT];
   assign fixed_period_pwm_select_n = function_control_reg[`FC_FIXED_PWM_N_BIT];
   assign count_source_code[0] = ch0_control_reg[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
   assign count_source_code[1] = ch1_control_reg[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
   assign combined = (combination_mode_field != `CMD_PLAIN);
   assign fixed_mode = !combined && !fixed_period_pwm_select_n;

   // one wait state on every access: accepted at the first edge, completed at the next
   assign word_addr = {address[7:2], 2'b00};
   assign accept = (read || write) && waitrequest;
   assign wr_go = write && !waitrequest;
   assign cmp_hit = (word_addr[7:5] == `OFS_COMPARE_BASE);
   assign cmp_merged = merge({{(32-W){1'b0}}, cmp[word_addr[4]][word_addr[3:2]]},
                             writedata, byteenable);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0;
      end else if (accept) begin
         waitrequest <= 1'b0;
         readdata <= rd_mux;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      case (word_addr)
         `OFS_OUTPUT_DISABLE: rd_mux[7:0] = timer_output_disable_reg;
         `OFS_FUNCTION_CONTROL: rd_mux[3:0] = function_control_reg;
         `OFS_PWM_MODE_SELECT: rd_mux[7:0] = pwm_mode_select_reg;
         `OFS_CH0_IO_AB: rd_mux[7:0] = ch0_io_control_ab;
         `OFS_CH0_IO_CD: rd_mux[7:0] = ch0_io_control_cd;
         `OFS_CH1_IO_AB: rd_mux[7:0] = ch1_io_control_ab;
         `OFS_CH1_IO_CD: rd_mux[7:0] = ch1_io_control_cd;
         `OFS_CH0_CONTROL: rd_mux[4:0] = ch0_control_reg;
         `OFS_CH1_CONTROL: rd_mux[4:0] = ch1_control_reg;
         `OFS_PORT_DIRECTION: rd_mux[7:0] = port2_direction_reg;
         `OFS_PORT_DATA: rd_mux[7:0] = port2_data_reg;
         `OFS_PIN_STATUS: rd_mux[24:0] = {op_clock_fast, timer_owned, ~timer_pin_oe_n,
                                          timer_pin_in};
         `OFS_DEAD_TIME: rd_mux[W-1:0] = dead_time_reg;
         `OFS_CH0_COUNT: rd_mux[W-1:0] = cnt[0];
         `OFS_CH1_COUNT: rd_mux[W-1:0] = cnt[1];
         default: begin
            if (cmp_hit) begin
               rd_mux[W-1:0] = cmp[word_addr[4]][word_addr[3:2]];
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         timer_output_disable_reg <= `RST_OUTPUT_DISABLE;
         function_control_reg <= `RST_FUNCTION_CONTROL;
         pwm_mode_select_reg <= 8'h00;
         ch0_io_control_ab <= 8'h00;
         ch0_io_control_cd <= 8'h00;
         ch1_io_control_ab <= 8'h00;
         ch1_io_control_cd <= 8'h00;
         ch0_control_reg <= 5'h00;
         ch1_control_reg <= 5'h00;
         port2_direction_reg <= 8'h00;
         port2_data_reg <= 8'h00;
         dead_time_reg <= '0;
      end else if (wr_go && byteenable[0]) begin
         case (word_addr)
            `OFS_OUTPUT_DISABLE: timer_output_disable_reg <= writedata[7:0];
            `OFS_FUNCTION_CONTROL: function_control_reg <= writedata[3:0];
            `OFS_PWM_MODE_SELECT: pwm_mode_select_reg <= writedata[7:0] & `MASK_PWM_SELECT;
            `OFS_CH0_IO_AB: ch0_io_control_ab <= writedata[7:0] & `MASK_IO_AB_CH0;
            `OFS_CH0_IO_CD: ch0_io_control_cd <= writedata[7:0] & `MASK_IO_CD;
            `OFS_CH1_IO_AB: ch1_io_control_ab <= writedata[7:0] & `MASK_IO_AB_CH1;
            `OFS_CH1_IO_CD: ch1_io_control_cd <= writedata[7:0] & `MASK_IO_CD;
            `OFS_CH0_CONTROL: ch0_control_reg <= writedata[4:0];
            `OFS_CH1_CONTROL: ch1_control_reg <= writedata[4:0];
            `OFS_PORT_DIRECTION: port2_direction_reg <= writedata[7:0];
            `OFS_PORT_DATA: port2_data_reg <= writedata[7:0];
            `OFS_DEAD_TIME: dead_time_reg[7:0] <= writedata[7:0];
            default: ;
         endcase
      end
      if (!reset && wr_go && byteenable[1] && word_addr == `OFS_DEAD_TIME) begin
         dead_time_reg[W-1:8] <= writedata[W-1:8];
      end
   end

   // operation clock choice is a count enable: the timer itself stays on ref_clk
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prescale <= 5'h00;
         op_clock_fast <= 1'b0;
      end else begin
         prescale <= prescale + 5'h01;
         op_clock_fast <= (count_source_code[0] == `SRC_FAST_OSC)
                          && (count_source_code[1] == `SRC_FAST_OSC);
      end
   end

   assign ext_tick = (func[0] == FUNC_EXT_CLOCK) && timer_pin_in[0] && !pin_prev[0];
   assign src_tick[0] = pick_tick(count_source_code[0], prescale, ext_tick,
                                  fast_onchip_osc_clock_tick);
   assign src_tick[1] = pick_tick(count_source_code[1], prescale, ext_tick,
                                  fast_onchip_osc_clock_tick);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_prev <= 8'h00;
      end else begin
         pin_prev <= timer_pin_in;
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_ch
      assign cmp_we[c] = (wr_go && cmp_hit && word_addr[4] == c) ?
                         (4'h1 << word_addr[3:2]) : 4'h0;
      timer_channel #(.W(W)) u_channel (
         .ref_clk(ref_clk),
         .reset(reset),
         .tick(src_tick[c]),
         .run(c == 0 ? ch0_control_reg[`CTRL_RUN_BIT] : ch1_control_reg[`CTRL_RUN_BIT]),
         .tri_mode(c == 0 && combination_mode_field[1]),
         .clear_on_a(c == 0 ? (ch0_control_reg[`CTRL_CLEAR_A_BIT] || combined || fixed_mode)
                            : ch1_control_reg[`CTRL_CLEAR_A_BIT]),
         .cap_en(cap_en[c]),
         .cmp_we(cmp_we[c]),
         .cmp_wdata(cmp_merged[W-1:0]),
         .count(cnt[c]),
         .count_up(cnt_up[c]),
         .cmp(cmp[c]),
         .match(match[c])
      );
   end

   // each pin decoded on its own, so functions mix freely within a channel in plain mode with fixed-period PWM off
   for (genvar i = 0; i < 8; i++) begin : g_pin
      localparam int CH = i / 4;
      localparam int K = i % 4;
      localparam int DC = (i < 4) ? 0 : 1;
      localparam int DK = (i == 4 || i == 6) ? 0 : 1;
      localparam bit NEG = (i == 3 || i == 6 || i == 7);
      logic [2:0] io_field;
      logic [W:0] duty;
      logic [W:0] duty_dead;
      logic oc_level;
      logic rise;
      logic fall;

      assign io_field = (CH == 0) ?
         ((K < 2) ? ch0_io_control_ab[(K%2)*4 +: 3] : ch0_io_control_cd[(K%2)*4 +: 3]) :
         ((K < 2) ? ch1_io_control_ab[(K%2)*4 +: 3] : ch1_io_control_cd[(K%2)*4 +: 3]);
      assign duty = {1'b0, cmp[DC][DK]};
      assign duty_dead = duty + {1'b0, dead_time_reg};
      assign rise = timer_pin_in[i] && !pin_prev[i];
      assign fall = !timer_pin_in[i] && pin_prev[i];

      pin_function_decode #(.IS_FIRST(i == 0), .HAS_FIXED(i < 2), .HAS_PWM(K != 0)) u_dec (
         .output_disable(timer_output_disable_reg[i]),
         .fixed_period_pwm_select_n(fixed_period_pwm_select_n),
         .external_clock_select(external_clock_select),
         .combination_mode_field(combination_mode_field),
         .pwm_select(pwm_mode_select_reg[i]),
         .io_extra_bit(ch0_io_control_ab[`IO_EXTRA_BIT]),
         .io_field(io_field),
         .func(func[i])
      );

      assign cap_en[CH][K] = (func[i] == FUNC_CAPTURE) &&
                             ((io_field == `IO_CAP_RISE) ? rise :
                              (io_field == `IO_CAP_FALL) ? fall : (rise || fall));

      always_ff @(posedge ref_clk) begin
         if (reset) begin
            oc_level <= 1'b0;
         end else if (func[i] == FUNC_OUT_COMPARE && match[CH][K]) begin
            case (io_field)
               `IO_OUT_LOW: oc_level <= 1'b0;
               `IO_OUT_HIGH: oc_level <= 1'b1;
               `IO_OUT_TOGGLE: oc_level <= !oc_level;
               default: oc_level <= oc_level;
            endcase
         end
      end

      always_comb begin
         next_out[i] = 1'b0;
         next_drive[i] = 1'b1;
         case (func[i])
            FUNC_COMPL_PWM: begin
               // both legs low inside the dead band around each crossing
               if (i == 2) begin
                  next_out[i] = cnt_up[0];
               end else if (NEG) begin
                  next_out[i] = {1'b0, cnt[0]} < duty;
               end else begin
                  next_out[i] = {1'b0, cnt[0]} >= duty_dead;
               end
            end
            FUNC_RSYNC_PWM: begin
               next_out[i] = (({1'b0, cnt[0]} < duty) != NEG);
            end
            FUNC_FIXED_PWM: begin
               next_out[i] = cnt[0] < ((i == 0) ? cmp[0][1] : cmp[1][0]);
            end
            FUNC_PLAIN_PWM: next_out[i] = cnt[CH] < cmp[CH][K];
            FUNC_OUT_COMPARE: next_out[i] = oc_level;
            FUNC_CAPTURE: next_drive[i] = 1'b0;
            FUNC_EXT_CLOCK: next_drive[i] = 1'b0;
            FUNC_GPIO: begin
               next_out[i] = port2_data_reg[i];
               next_drive[i] = port2_direction_reg[i];
            end
            default: next_drive[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         timer_pin_out <= 8'h00;
         timer_pin_oe_n <= 8'hff;
         timer_owned <= 8'h00;
      end else begin
         timer_pin_out <= next_out;
         timer_pin_oe_n <= ~next_drive;
         for (int p = 0; p < 8; p++) begin
            timer_owned[p] <= (func[p] != FUNC_GPIO);
         end
      end
   end

endmodule : dual_timer_pin_select

// ---- hdl/timer_pin_consts.svh ----
`ifndef TIMER_PIN_CONSTS_SVH
`define TIMER_PIN_CONSTS_SVH

// register byte addresses, one 32-bit word each; the compare base is address bits 7:5 of an eight-word block
`define OFS_OUTPUT_DISABLE 8'h00
`define OFS_FUNCTION_CONTROL 8'h04
`define OFS_PWM_MODE_SELECT 8'h08
`define OFS_CH0_IO_AB 8'h0c
`define OFS_CH0_IO_CD 8'h10
`define OFS_CH1_IO_AB 8'h14
`define OFS_CH1_IO_CD 8'h18
`define OFS_CH0_CONTROL 8'h1c
`define OFS_CH1_CONTROL 8'h20
`define OFS_PORT_DIRECTION 8'h24
`define OFS_PORT_DATA 8'h28
`define OFS_PIN_STATUS 8'h2c
`define OFS_DEAD_TIME 8'h30
`define OFS_COMPARE_BASE 3'h2
`define OFS_CH0_COUNT 8'h60
`define OFS_CH1_COUNT 8'h64

// reset values
`define RST_OUTPUT_DISABLE 8'hff
`define RST_FUNCTION_CONTROL 4'h8

// writable bit masks, reserved bits read as zero
`define MASK_IO_AB_CH0 8'h7f
`define MASK_IO_AB_CH1 8'h77
`define MASK_IO_CD 8'h77
`define MASK_PWM_SELECT 8'hee

// field positions
`define FC_CMD_LSB 0
`define FC_CMD_MSB 1
`define FC_EXT_CLK_BIT 2
`define FC_FIXED_PWM_N_BIT 3
`define IO_EXTRA_BIT 3
`define CTRL_SRC_LSB 0
`define CTRL_SRC_MSB 2
`define CTRL_RUN_BIT 3
`define CTRL_CLEAR_A_BIT 4

// combination mode and code values
`define CMD_PLAIN 2'h0
`define CMD_RESET_SYNC 2'h1
`define IO_OUT_LOW 3'h1
`define IO_OUT_HIGH 3'h2
`define IO_OUT_TOGGLE 3'h3
`define IO_CAP_RISE 3'h4
`define IO_CAP_FALL 3'h5
`define IO_EXT_CLOCK 3'h0
`define SRC_DIV1 3'h0
`define SRC_DIV2 3'h1
`define SRC_DIV4 3'h2
`define SRC_DIV8 3'h3
`define SRC_DIV32 3'h4
`define SRC_EXT 3'h5
`define SRC_FAST_OSC 3'h6

`endif

// ---- hdl/timer_pin_pkg.sv ----
package timer_pin_pkg;

   typedef enum logic [7:0] {
      FUNC_GPIO = 8'h01,
      FUNC_COMPL_PWM = 8'h02,
      FUNC_RSYNC_PWM = 8'h04,
      FUNC_FIXED_PWM = 8'h08,
      FUNC_PLAIN_PWM = 8'h10,
      FUNC_OUT_COMPARE = 8'h20,
      FUNC_CAPTURE = 8'h40,
      FUNC_EXT_CLOCK = 8'h80
   } pin_func_t;

endpackage : timer_pin_pkg

// ---- hdl/pin_function_decode.sv ----
`timescale 1ns/10ps
`include "timer_pin_consts.svh"

module pin_function_decode
   import timer_pin_pkg::*;
#(
   parameter bit IS_FIRST = 1'b0,
   parameter bit HAS_FIXED = 1'b0,
   parameter bit HAS_PWM = 1'b1
)
(
   input wire logic output_disable,
   input wire logic fixed_period_pwm_select_n,
   input wire logic external_clock_select,
   input wire logic [1:0] combination_mode_field,
   input wire logic pwm_select,
   input wire logic io_extra_bit,
   input wire logic [2:0] io_field,
   output pin_func_t func
);

   logic plain;
   logic oc_code;

   always_comb begin
      plain = (combination_mode_field == `CMD_PLAIN);
      oc_code = (io_field == `IO_OUT_LOW) || (io_field[2:1] == 2'b01);
      func = FUNC_GPIO;
      if (IS_FIRST) begin
         if (!output_disable && !fixed_period_pwm_select_n && !external_clock_select && plain) begin
            func = FUNC_FIXED_PWM;
         end else if (!output_disable && fixed_period_pwm_select_n && !external_clock_select
                      && plain && io_extra_bit && oc_code) begin
            func = FUNC_OUT_COMPARE;
         end else if (fixed_period_pwm_select_n && !external_clock_select && plain
                      && io_field[2]) begin
            func = FUNC_CAPTURE;
         end else if (fixed_period_pwm_select_n && external_clock_select
                      && io_field == `IO_EXT_CLOCK) begin
            func = FUNC_EXT_CLOCK;
         end
      end else begin
         if (!output_disable && combination_mode_field[1]) begin
            func = FUNC_COMPL_PWM;
         end else if (!output_disable && combination_mode_field == `CMD_RESET_SYNC) begin
            func = FUNC_RSYNC_PWM;
         end else if (plain && !fixed_period_pwm_select_n) begin
            if (HAS_FIXED && !output_disable) begin
               func = FUNC_FIXED_PWM;
            end
         end else if (plain) begin
            if (HAS_PWM && pwm_select) begin
               if (!output_disable) begin
                  func = FUNC_PLAIN_PWM;
               end
            end else if (!output_disable && oc_code) begin
               func = FUNC_OUT_COMPARE;
            end else if (io_field[2]) begin
               func = FUNC_CAPTURE;
            end
         end
      end
   end

endmodule : pin_function_decode

// ---- hdl/timer_channel.sv ----
`timescale 1ns/10ps

module timer_channel #(
   parameter int W = 16
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic run,
   input wire logic tri_mode,
   input wire logic clear_on_a,
   input wire logic [3:0] cap_en,
   input wire logic [3:0] cmp_we,
   input wire logic [W-1:0] cmp_wdata,
   output logic [W-1:0] count,
   output logic count_up,
   output logic [3:0][W-1:0] cmp,
   output logic [3:0] match
);

   // 16-bit counter: sawtooth, or triangle for complementary output
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count <= '0;
         count_up <= 1'b1;
      end else if (run && tick) begin
         if (tri_mode) begin
            if (count_up && count >= cmp[0] && count != '0) begin
               count_up <= 1'b0;
               count <= count - 1'b1;
            end else if (!count_up && count == '0) begin
               count_up <= 1'b1;
               count <= count + 1'b1;
            end else if (count_up) begin
               count <= count + 1'b1;
            end else begin
               count <= count - 1'b1;
            end
         end else begin
            count_up <= 1'b1;
            if (clear_on_a && count == cmp[0]) begin
               count <= '0;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end

   // a capture in the same cycle as a bus write wins, so no edge is lost
   for (genvar k = 0; k < 4; k++) begin : g_cmp
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            cmp[k] <= '1;
         end else if (cap_en[k]) begin
            cmp[k] <= count;
         end else if (cmp_we[k]) begin
            cmp[k] <= cmp_wdata;
         end
      end
      assign match[k] = run && tick && (count == cmp[k]);
   end

endmodule : timer_channel

// ---- tb/pin_partner.sv ----
`timescale 1ns/10ps

module pin_partner (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] oe_n,
   input wire logic [7:0] drive,
   output logic [7:0] pin_level
);
   // released pins follow the far side, so capture pins really see our edges
   assign pin_level = (oe_n & drive) | (~oe_n & pin_out);
endmodule : pin_partner

// ---- tb/timer_pin_properties.sv ----
`timescale 1ns/10ps

module timer_pin_properties (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [7:0] timer_pin_oe_n,
   input wire logic op_clock_fast
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   accept_gives_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no answer after accept");
   single_answer_a: assert property (!waitrequest |=> waitrequest)
      else $error("answer longer than one cycle");
   answer_has_cause_a: assert property (!waitrequest |-> $past(read || write))
      else $error("answer without request");
   readdata_holds_a: assert property (waitrequest && !$past(reset) |-> $stable(readdata))
      else $error("read data moved between accesses");
   unmapped_zero_a: assert property (read && !waitrequest && address >= 8'h68 |-> readdata == 0)
      else $error("unmapped read not zero");
   reset_state_a: assert property ($past(reset) |-> timer_pin_oe_n == 8'hff && !op_clock_fast)
      else $error("pins or clock flag wrong after reset");
   oe_after_write_a: assert property (!$past(reset) && !$stable(timer_pin_oe_n)
      |-> $past(write && !waitrequest, 2))
      else $error("pin drive changed without a write");
   fast_after_write_a: assert property (!$past(reset) && !$stable(op_clock_fast)
      |-> $past(write && !waitrequest, 2))
      else $error("clock flag changed without a write");

   cover property ($rose(op_clock_fast));
   cover property ($fell(timer_pin_oe_n[1]));
   cover property (read && !waitrequest && address >= 8'h68);
endmodule : timer_pin_properties

bind dual_timer_pin_select timer_pin_properties timer_pin_properties_i (.ref_clk, .reset,
   .address, .read, .write, .readdata, .waitrequest, .timer_pin_oe_n, .op_clock_fast);

// ---- tb/tb_dual_timer_pin_select.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end

module tb_dual_timer_pin_select;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe_n;
   logic [7:0] drive = 8'h00;
   logic tick = 1'b0;
   logic op_fast;
   logic [31:0] rdv;
   logic p;
   int fails = 0;
   int comparisons = 0;
   // function ctrl, disable, pwm select, io ab, expected oe_n, expected timer-owned
   localparam logic [47:0] cfg_tbl [12] = '{
      48'h02_00_00_00_01_fe, 48'h01_02_00_00_03_fc, 48'h00_00_00_00_fc_03,
      48'h04_00_00_00_fd_02, 48'h08_00_02_00_fd_02, 48'h08_fd_00_20_fd_02,
      48'h08_ff_00_20_ff_00, 48'h08_00_00_01_ff_00, 48'h08_00_00_09_fe_01,
      48'h08_00_00_40_ff_02, 48'h0c_00_00_00_ff_01, 48'h0c_00_00_09_ff_00};

   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) tick <= ~tick;

   dual_timer_pin_select dual_timer_pin_select_i (.ref_clk(ref_clk), .reset(reset),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
      .timer_pin_in(pin_in), .timer_pin_out(pin_out), .timer_pin_oe_n(pin_oe_n),
      .fast_onchip_osc_clock_tick(tick), .op_clock_fast(op_fast));
   pin_partner pin_partner_i (.pin_out(pin_out), .oe_n(pin_oe_n), .drive(drive),
      .pin_level(pin_in));

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      read <= 1'b1;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
   endtask : rd

   task automatic test_done;
      $display("mismatches %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   initial begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      test_done();
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      `CHK("oe_n", 8'hff, pin_oe_n)
      rd(8'h00, rdv);
      `CHK("disable", 32'hff, rdv)
      rd(8'h04, rdv);
      `CHK("function", 32'h8, rdv)
      for (int c = 0; c < 7; c++) begin
         wr(8'h1c, 32'(c));
         wr(8'h20, 32'(c));
         repeat (3) @(posedge ref_clk);
         `CHK("op_fast", c == 6, op_fast)
      end
      wr(8'h20, 32'h5);
      repeat (3) @(posedge ref_clk);
      `CHK("op_fast", 1'b0, op_fast)
      wr(8'h1c, 32'h0);
      wr(8'h20, 32'h0);
      // every pin-function row: combined, fixed, plain, compare, capture, ext clock
      for (int i = 0; i < 12; i++) begin
         wr(8'h04, {24'h0, cfg_tbl[i][47:40]});
         wr(8'h00, {24'h0, cfg_tbl[i][39:32]});
         wr(8'h08, {24'h0, cfg_tbl[i][31:24]});
         wr(8'h0c, {24'h0, cfg_tbl[i][23:16]});
         repeat (3) @(posedge ref_clk);
         `CHK("oe_n", cfg_tbl[i][15:8], pin_oe_n)
         rd(8'h2c, rdv);
         `CHK("owned", cfg_tbl[i][7:0], rdv[23:16])
      end
      // counter never ran, so a capture must load zero
      wr(8'h04, 32'h8);
      wr(8'h0c, 32'h0);
      wr(8'h10, 32'h4);
      @(posedge ref_clk);
      drive <= 8'h04;
      repeat (4) @(posedge ref_clk);
      rd(8'h48, rdv);
      `CHK("capture", 32'h0, rdv)
      wr(8'h0c, 32'h30);
      wr(8'h00, 32'hfd);
      wr(8'h44, 32'h5);
      p = pin_out[1];
      wr(8'h1c, 32'h8);
      repeat (20) @(posedge ref_clk);
      `CHK("toggle", ~p, pin_out[1])
      // pin a matches no timer setting here, so the port registers own it
      wr(8'h28, 32'h1);
      wr(8'h24, 32'h1);
      repeat (3) @(posedge ref_clk);
      `CHK("gpio oe_n", 8'hfc, pin_oe_n)
      `CHK("gpio out", 1'b1, pin_out[0])
      rd(8'hfc, rdv);
      `CHK("unmapped", 32'h0, rdv)
      test_done();
   end
endmodule : tb_dual_timer_pin_select
